// *** src/msip_packetizer.v ***
// Six-sensor image packetizer: register port, sensor sequencer, byte FIFO
// and isochronous packet transmitter.
// Assumes a byte source that serves the sensor and plane it is asked for
// and a packet sink with valid/ready handshake, all on SYS_CLK_I.
`timescale 1ns/100ps
`default_nettype none
`include "msip_defines.vh"

module msip_fifo #(
  parameter WIDTH = 8,
  parameter DEPTH = 16,
  parameter AW = 4
) (
  input wire clk_i,
  input wire rst_n_i,
  input wire in_valid_i,
  output wire in_ready_o,
  input wire [WIDTH-1:0] in_data_i,
  output wire out_valid_o,
  input wire out_ready_i,
  output wire [WIDTH-1:0] out_data_o,
  output wire afull_o
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];
  reg [AW-1:0] wr_q;
  reg [AW-1:0] rd_q;
  reg [AW:0] cnt_q;
  wire push = in_valid_i && in_ready_o;
  wire pop = out_valid_o && out_ready_i;
  assign in_ready_o = (cnt_q != DEPTH[AW:0]);
  assign out_valid_o = (cnt_q != {(AW+1){1'b0}});
  assign out_data_o = mem[rd_q];
  // Leaves room for one byte already in flight behind a registered ready.
  assign afull_o = (cnt_q >= DEPTH[AW:0] - {{(AW-1){1'b0}}, 2'h2});
  always @(posedge clk_i) begin
    if (push) begin
      mem[wr_q] <= in_data_i;
    end
  end
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_q <= {AW{1'b0}};
      rd_q <= {AW{1'b0}};
      cnt_q <= {(AW+1){1'b0}};
    end else begin
      if (push) begin
        wr_q <= (wr_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : wr_q + 1'b1;
      end
      if (pop) begin
        rd_q <= (rd_q == DEPTH[AW-1:0] - 1'b1) ? {AW{1'b0}} : rd_q + 1'b1;
      end
      if (push && !pop) begin
        cnt_q <= cnt_q + 1'b1;
      end else if (pop && !push) begin
        cnt_q <= cnt_q - 1'b1;
      end
    end
  end
endmodule

// Operation
// R01 - After reset the block runs the custom partial-image format in mode 0 with no setup.
// R02 - Only modes 0, 1, 2, 3, 6 and 7 are accepted; other mode writes are ignored.
// R03 - Each frame carries one sub-image from each of the six sensors.
// R04 - Modes 1, 3 and 7 send four half-size Bayer planes per sensor.
// R05 - Modes 2 and 3 ask the source for row-binned half-height images.
// R06 - The frame starts at the selected sensor and continues upward modulo six.
// R07 - The host keeps the start sensor at 0 in modes 0 and 2 for correct stitching.
// R08 - At most one packet leaves per 125 us bus cycle.
// R09 - Packets per frame and bytes per packet are readable.
// R10 - A read-only register tells whether standard or Bayer binning applies.
// R11 - The host stops, reconfigures and restarts when changing size or encoding.
// R12 - The host trims computed image height by 0.95 to spare bus bandwidth.
// R13 - Packet payload never exceeds the allocated 8192 bytes.
// R14 - Sensor sub-images of a frame go out back to back in the selected order.
module msip_packetizer #(
  parameter [12:0] CYCLE_CLKS = `MSIP_CYCLE_CLKS,
  parameter FIFO_DEPTH = 16,
  parameter FIFO_AW = 4
) (
  // Clock and reset.
  input wire SYS_CLK_I,
  input wire RESETN_I,
  // Register port.
  input wire REG_WR_I,
  input wire REG_RD_I,
  input wire [15:0] REG_ADDR_I,
  input wire [31:0] REG_WDATA_I,
  output reg [31:0] REG_RDATA_O,
  output reg REG_RACK_O,
  // Image byte source.
  input wire SRC_VALID_I,
  input wire [7:0] SRC_DATA_I,
  output reg SRC_READY_O,
  output reg [2:0] SRC_SENSOR_O,
  output reg [1:0] SRC_PLANE_O,
  output reg SRC_BIN_O,
  output reg SRC_BAYER_O,
  // Isochronous packet output.
  output reg TX_VALID_O,
  output reg [7:0] TX_DATA_O,
  output reg TX_SOP_O,
  output reg TX_EOP_O,
  output reg TX_SOF_O,
  input wire TX_READY_I
);
  localparam SEQ_IDLE = 2'b01;
  localparam SEQ_RUN = 2'b10;
  localparam TX_IDLE = 3'b001;
  localparam TX_WAIT = 3'b010;
  localparam TX_SEND = 3'b100;
  localparam [12:0] CYC_LAST = CYCLE_CLKS - 13'h0001;

  reg [2:0] start_q;
  reg [2:0] mode_q;
  reg iso_en_q;
  reg [13:0] bpp_q;
  // Packets-per-frame divider.
  reg [23:0] div_rem_q;
  reg [15:0] ppf_q;
  reg [15:0] div_cnt_q;
  reg div_busy_q;
  // Sequencer.
  reg [1:0] seq_q;
  reg [2:0] seq_mode_q;
  reg [2:0] sens_done_q;
  reg [23:0] left_q;
  reg [23:0] frame_bytes_q;
  // Transmitter.
  reg [2:0] tx_q;
  reg [12:0] cyc_q;
  reg [23:0] frame_left_q;
  reg [13:0] pkt_left_q;
  reg [13:0] tx_bpp_q;
  reg pkt_first_q;

  wire mode_ok = (REG_WDATA_I[2:0] != 3'h4) && (REG_WDATA_I[2:0] != 3'h5); // [R02]
  wire wr_mode = REG_WR_I && (REG_ADDR_I == `MSIP_OFS_MODE) && mode_ok;
  wire wr_bpp = REG_WR_I && (REG_ADDR_I == `MSIP_OFS_BPP);
  wire half = (mode_q == `MSIP_MODE_RAWHALF) || (mode_q == `MSIP_MODE_SEPHALF);
  wire sep = (mode_q == `MSIP_MODE_SEP) || (mode_q == `MSIP_MODE_SEPHALF) ||
    (mode_q == `MSIP_MODE_SEPJPG);
  wire [23:0] frame_bytes = half ? `MSIP_FRAME_HALF : `MSIP_FRAME_FULL; // [R03]
  wire seq_sep = (seq_mode_q == `MSIP_MODE_SEP) || (seq_mode_q == `MSIP_MODE_SEPHALF) ||
    (seq_mode_q == `MSIP_MODE_SEPJPG);
  reg [23:0] plane_bytes;
  always @* begin
    case (mode_q)
      `MSIP_MODE_RAWHALF: plane_bytes = `MSIP_PLANE_HALF;
      `MSIP_MODE_SEPHALF: plane_bytes = `MSIP_PLANE_SEPHALF;
      `MSIP_MODE_SEP, `MSIP_MODE_SEPJPG: plane_bytes = `MSIP_PLANE_SEP; // [R04]
      default: plane_bytes = `MSIP_PLANE_FULL;
    endcase
  end

  // Register writes and reads.
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_q <= `MSIP_START_RST;
      mode_q <= `MSIP_MODE_RST; // [R01]
      iso_en_q <= 1'b0;
      bpp_q <= `MSIP_BPP_RST;
      REG_RDATA_O <= 32'h00000000;
      REG_RACK_O <= 1'b0;
    end else begin
      if (REG_WR_I && (REG_ADDR_I == `MSIP_OFS_START) &&
          (REG_WDATA_I[2:0] <= `MSIP_LAST_SENSOR)) begin
        start_q <= REG_WDATA_I[2:0]; // [R06]
      end
      if (wr_mode) begin
        mode_q <= REG_WDATA_I[2:0]; // [R02]
      end
      if (REG_WR_I && (REG_ADDR_I == `MSIP_OFS_ISOEN)) begin
        iso_en_q <= REG_WDATA_I[0];
      end
      if (wr_bpp) begin
        if (REG_WDATA_I > {18'h00000, `MSIP_BPP_MAX}) begin
          bpp_q <= `MSIP_BPP_MAX; // [R13]
        end else if (REG_WDATA_I < {18'h00000, `MSIP_BPP_MIN}) begin
          bpp_q <= `MSIP_BPP_MIN;
        end else begin
          bpp_q <= REG_WDATA_I[13:0];
        end
      end
      REG_RACK_O <= REG_RD_I;
      if (REG_RD_I) begin
        case (REG_ADDR_I)
          `MSIP_OFS_START: REG_RDATA_O <= {`MSIP_START_FLAGS, start_q};
          `MSIP_OFS_BINFO: REG_RDATA_O <= {30'h00000000, half && sep, half}; // [R10]
          `MSIP_OFS_ISOEN: REG_RDATA_O <= {30'h00000000, seq_q == SEQ_RUN, iso_en_q};
          `MSIP_OFS_MODE: REG_RDATA_O <= {29'h00000000, mode_q};
          `MSIP_OFS_BPP: REG_RDATA_O <= {18'h00000, bpp_q}; // [R09]
          `MSIP_OFS_PPF: REG_RDATA_O <= {div_busy_q, 15'h0000, ppf_q}; // [R09]
          default: REG_RDATA_O <= 32'h00000000;
        endcase
      end
    end
  end

  // Ceiling of frame bytes over packet bytes, recomputed after each change.
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      div_busy_q <= 1'b1;
      div_rem_q <= `MSIP_FRAME_FULL;
      div_cnt_q <= 16'h0000;
      ppf_q <= 16'h0000;
    end else if (wr_mode || wr_bpp) begin
      div_busy_q <= 1'b1;
      div_rem_q <= 24'h000000;
      div_cnt_q <= 16'hFFFF;
    end else if (div_busy_q) begin
      if (div_cnt_q == 16'hFFFF) begin
        div_rem_q <= frame_bytes;
        div_cnt_q <= 16'h0000;
      end else if (div_rem_q > {10'h000, bpp_q}) begin
        div_rem_q <= div_rem_q - {10'h000, bpp_q};
        div_cnt_q <= div_cnt_q + 16'h0001;
      end else begin
        ppf_q <= div_cnt_q + 16'h0001; // [R09]
        div_busy_q <= 1'b0;
      end
    end
  end

  // Byte FIFO between sequencer and transmitter.
  wire fifo_in_ready;
  wire fifo_out_valid;
  wire [7:0] fifo_out_data;
  wire fifo_afull;
  wire accept = SRC_VALID_I && SRC_READY_O && fifo_in_ready;
  wire tx_load = (tx_q == TX_SEND) && fifo_out_valid && (!TX_VALID_O || TX_READY_I);
  msip_fifo #(
    .WIDTH(8),
    .DEPTH(FIFO_DEPTH),
    .AW(FIFO_AW)
  ) u_fifo (
    .clk_i(SYS_CLK_I),
    .rst_n_i(RESETN_I),
    .in_valid_i(SRC_VALID_I && SRC_READY_O),
    .in_ready_o(fifo_in_ready),
    .in_data_i(SRC_DATA_I),
    .out_valid_o(fifo_out_valid),
    .out_ready_i(tx_load),
    .out_data_o(fifo_out_data),
    .afull_o(fifo_afull)
  );

  // Sequencer: sensors in order from the start sensor, planes within a sensor.
  reg [1:0] seq_d;
  wire last_byte = accept && (left_q == 24'h000001);
  wire last_plane = !seq_sep || (SRC_PLANE_O == `MSIP_LAST_PLANE);
  wire frame_end = last_byte && last_plane && (sens_done_q == `MSIP_LAST_SENSOR);
  always @* begin
    case (seq_q)
      SEQ_IDLE: seq_d = iso_en_q ? SEQ_RUN : SEQ_IDLE;
      SEQ_RUN: seq_d = (frame_end && !iso_en_q) ? SEQ_IDLE : SEQ_RUN;
      default: seq_d = SEQ_IDLE;
    endcase
  end
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      seq_q <= SEQ_IDLE;
      seq_mode_q <= `MSIP_MODE_RST;
      sens_done_q <= 3'h0;
      left_q <= 24'h000000;
      frame_bytes_q <= `MSIP_FRAME_FULL;
      SRC_READY_O <= 1'b0;
      SRC_SENSOR_O <= 3'h0;
      SRC_PLANE_O <= 2'h0;
      SRC_BIN_O <= 1'b0;
      SRC_BAYER_O <= 1'b0;
    end else begin
      seq_q <= seq_d;
      SRC_READY_O <= (seq_d == SEQ_RUN) && !fifo_afull;
      if (((seq_q == SEQ_IDLE) && iso_en_q) || (frame_end && iso_en_q)) begin
        seq_mode_q <= mode_q;
        frame_bytes_q <= frame_bytes;
        sens_done_q <= 3'h0;
        left_q <= plane_bytes;
        SRC_SENSOR_O <= start_q; // [R06]
        SRC_PLANE_O <= 2'h0;
        SRC_BIN_O <= half; // [R05]
        SRC_BAYER_O <= half && sep;
      end else if (last_byte) begin
        left_q <= (seq_sep && (seq_mode_q == `MSIP_MODE_SEPHALF)) ? `MSIP_PLANE_SEPHALF :
          seq_sep ? `MSIP_PLANE_SEP :
          (seq_mode_q == `MSIP_MODE_RAWHALF) ? `MSIP_PLANE_HALF : `MSIP_PLANE_FULL;
        if (last_plane) begin
          SRC_PLANE_O <= 2'h0;
          sens_done_q <= sens_done_q + 3'h1; // [R14]
          SRC_SENSOR_O <= (SRC_SENSOR_O == `MSIP_LAST_SENSOR) ? 3'h0 :
            SRC_SENSOR_O + 3'h1; // [R06]
        end else begin
          SRC_PLANE_O <= SRC_PLANE_O + 2'h1; // [R04]
        end
      end else if (accept) begin
        left_q <= left_q - 24'h000001;
      end
    end
  end

  // Transmitter: one packet may start only on a bus cycle tick.
  wire tick = (cyc_q == CYC_LAST);
  wire [13:0] pkt_len = (frame_left_q < {10'h000, tx_bpp_q}) ? frame_left_q[13:0] : tx_bpp_q;
  reg [2:0] tx_d;
  always @* begin
    case (tx_q)
      TX_IDLE: tx_d = fifo_out_valid ? TX_WAIT : TX_IDLE;
      TX_WAIT: tx_d = tick ? TX_SEND : TX_WAIT; // [R08]
      TX_SEND: begin
        if (tx_load && (pkt_left_q == 14'h0001)) begin
          tx_d = (frame_left_q == 24'h000001) ? TX_IDLE : TX_WAIT;
        end else begin
          tx_d = TX_SEND;
        end
      end
      default: tx_d = TX_IDLE;
    endcase
  end
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      tx_q <= TX_IDLE;
      cyc_q <= 13'h0000;
      frame_left_q <= 24'h000000;
      pkt_left_q <= 14'h0000;
      tx_bpp_q <= `MSIP_BPP_RST;
      pkt_first_q <= 1'b0;
      TX_VALID_O <= 1'b0;
      TX_DATA_O <= 8'h00;
      TX_SOP_O <= 1'b0;
      TX_EOP_O <= 1'b0;
      TX_SOF_O <= 1'b0;
    end else begin
      tx_q <= tx_d;
      cyc_q <= tick ? 13'h0000 : cyc_q + 13'h0001;
      if ((tx_q == TX_IDLE) && fifo_out_valid) begin
        frame_left_q <= frame_bytes_q;
        tx_bpp_q <= bpp_q;
      end
      if ((tx_q == TX_WAIT) && tick) begin
        pkt_left_q <= pkt_len; // [R13]
        pkt_first_q <= 1'b1;
      end
      if (tx_load) begin
        TX_VALID_O <= 1'b1;
        TX_DATA_O <= fifo_out_data;
        TX_SOP_O <= pkt_first_q;
        TX_SOF_O <= pkt_first_q && (frame_left_q == frame_bytes_q);
        TX_EOP_O <= (pkt_left_q == 14'h0001);
        pkt_first_q <= 1'b0;
        pkt_left_q <= pkt_left_q - 14'h0001;
        frame_left_q <= frame_left_q - 24'h000001;
      end else if (TX_READY_I) begin
        TX_VALID_O <= 1'b0;
        TX_SOP_O <= 1'b0;
        TX_EOP_O <= 1'b0;
        TX_SOF_O <= 1'b0;
      end
    end
  end
endmodule
`default_nettype wire

// *** include/msip_defines.vh ***
// Constants for the six-sensor image packetizer: register map, mode codes,
// image sizes and bus cycle timing. Definitions only.
`ifndef MSIP_DEFINES_VH
`define MSIP_DEFINES_VH

// Register offsets.
`define MSIP_OFS_START 16'h0884
`define MSIP_OFS_BINFO 16'h1AC8
`define MSIP_OFS_ISOEN 16'h0614
`define MSIP_OFS_MODE 16'h0A08
`define MSIP_OFS_BPP 16'h0A44
`define MSIP_OFS_PPF 16'h0A48

// Start sensor register: fixed flag bits above the sensor index field.
`define MSIP_START_FLAGS 29'h10400000
`define MSIP_START_RST 3'h0

// Binning information bit positions.
`define MSIP_BINFO_BIN 0
`define MSIP_BINFO_BAYER 1

// Supported modes.
`define MSIP_MODE_RAW 3'h0
`define MSIP_MODE_SEP 3'h1
`define MSIP_MODE_RAWHALF 3'h2
`define MSIP_MODE_SEPHALF 3'h3
`define MSIP_MODE_RAWJPG 3'h6
`define MSIP_MODE_SEPJPG 3'h7
`define MSIP_MODE_RST 3'h0

// Sensors and planes.
`define MSIP_LAST_SENSOR 3'h5
`define MSIP_LAST_PLANE 2'h3

// Bytes per plane and per frame (six sensors).
`define MSIP_PLANE_FULL 24'h1E6100
`define MSIP_PLANE_HALF 24'h0F3080
`define MSIP_PLANE_SEP 24'h079840
`define MSIP_PLANE_SEPHALF 24'h03CC20
`define MSIP_FRAME_FULL 24'hB64600
`define MSIP_FRAME_HALF 24'h5B2300

// Packet size limits and reset value.
`define MSIP_BPP_MIN 14'h0198
`define MSIP_BPP_MAX 14'h2000
`define MSIP_BPP_RST 14'h2000

// Bus cycle timing.
`define MSIP_CYCLE_NS 125000
`define MSIP_CLK_NS 20
// One 125 us bus cycle counted in 20 ns system clocks, sized for the cycle counter.
`define MSIP_CYCLE_CLKS 13'h186A

`endif

// *** verification/msip_packetizer_props.sv ***
// Port checks for the six-sensor packetizer: register answers and packets.
// Bound into every msip_packetizer; one clock, async active-low reset.
`timescale 1ns/100ps
`default_nettype none
module msip_packetizer_props #(
  parameter [12:0] CYCLE_CLKS = 13'h186A
) (
  input wire logic SYS_CLK_I,
  input wire logic RESETN_I,
  input wire logic REG_RD_I,
  input wire logic REG_RACK_O,
  input wire logic [2:0] SRC_SENSOR_O,
  input wire logic SRC_BIN_O,
  input wire logic SRC_BAYER_O,
  input wire logic TX_VALID_O,
  input wire logic [7:0] TX_DATA_O,
  input wire logic TX_SOP_O,
  input wire logic TX_EOP_O,
  input wire logic TX_SOF_O,
  input wire logic TX_READY_I
);
  default clocking cb @(posedge SYS_CLK_I); endclocking
  default disable iff (!RESETN_I);
  logic [13:0] gap_q;
  logic [13:0] len_q;
  logic hold_q;
  wire take = TX_VALID_O && TX_READY_I;
  // A start byte held by a stalled sink is not a new packet.
  wire sop_new = TX_VALID_O && TX_SOP_O && !hold_q;
  always @(posedge SYS_CLK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      gap_q <= 14'h3FFF;
      len_q <= 14'h0000;
      hold_q <= 1'b0;
    end else begin
      hold_q <= TX_VALID_O && TX_SOP_O && !TX_READY_I;
      if (sop_new)
        gap_q <= 14'h0001;
      else if (gap_q != 14'h3FFF)
        gap_q <= gap_q + 14'h0001;
      if (take)
        len_q <= TX_EOP_O ? 14'h0000 : len_q + 14'h0001;
    end
  end
  property p_rack; REG_RD_I |=> REG_RACK_O; endproperty
  a_rack: assert property (p_rack) else $error("read answer missing");
  property p_norack; !REG_RD_I |=> !REG_RACK_O; endproperty
  a_norack: assert property (p_norack) else $error("unasked read answer");
  property p_hold; TX_VALID_O && !TX_READY_I |=> TX_VALID_O && $stable(TX_DATA_O); endproperty
  a_hold: assert property (p_hold) else $error("packet byte dropped");
  property p_gap; sop_new |-> gap_q >= CYCLE_CLKS - 13'h0001; endproperty
  a_gap: assert property (p_gap) else $error("two packets in one cycle");
  property p_len; take && TX_EOP_O |-> len_q <= 14'h1FFF; endproperty
  a_len: assert property (p_len) else $error("packet too long");
  property p_sof; TX_VALID_O && TX_SOF_O |-> TX_SOP_O; endproperty
  a_sof: assert property (p_sof) else $error("frame start mid packet");
  property p_sensor; SRC_SENSOR_O <= 3'h5; endproperty
  a_sensor: assert property (p_sensor) else $error("sensor out of range");
  property p_bayer; SRC_BAYER_O |-> SRC_BIN_O; endproperty
  a_bayer: assert property (p_bayer) else $error("bayer without binning");
  property p_quiet; $rose(RESETN_I) |-> !TX_VALID_O && !REG_RACK_O; endproperty
  a_quiet: assert property (p_quiet) else $error("busy after reset");
endmodule
bind msip_packetizer msip_packetizer_props #(.CYCLE_CLKS(CYCLE_CLKS)) u_props (.*);
`default_nettype wire

// *** verification/msip_host_sink.sv ***
// Host adapter model taking isochronous packet bytes.
// Expects the bench source to number its bytes from zero.
`timescale 1ns/100ps
`default_nettype none
module msip_host_sink (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic stall_i,
  input wire logic valid_i,
  input wire logic [7:0] data_i,
  input wire logic sop_i,
  input wire logic eop_i,
  input wire logic sof_i,
  output logic ready_o,
  output logic [15:0] len_o,
  output logic [15:0] pkts_o,
  output logic [15:0] sofs_o,
  output logic [15:0] errs_o
);
  logic [15:0] cnt_q;
  logic [7:0] exp_q;
  logic tog_q;
  assign ready_o = !stall_i || tog_q;
  always @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      {cnt_q, exp_q, tog_q, len_o, pkts_o, sofs_o, errs_o} <= '0;
    end else begin
      tog_q <= !tog_q;
      if (valid_i && ready_o) begin
        exp_q <= exp_q + 8'h01;
        cnt_q <= eop_i ? 16'h0000 : cnt_q + 16'h0001;
        if (data_i !== exp_q || sop_i !== (cnt_q == 16'h0000))
          errs_o <= errs_o + 16'h0001;
        if (eop_i) begin
          len_o <= cnt_q + 16'h0001;
          pkts_o <= pkts_o + 16'h0001;
        end
        if (sof_i)
          sofs_o <= sofs_o + 16'h0001;
      end
    end
  end
endmodule
`default_nettype wire

// *** verification/tb_multi_sensor_image_packetizer.sv ***
// Self-checking bench for the six-sensor packetizer.
// Uses a counting byte source and the host sink model.
`timescale 1ns/100ps
`default_nettype none
`include "msip_defines.vh"
module tb_multi_sensor_image_packetizer;
  logic clk, rstn, wr, rd, rack, sval, srdy, sbin, sbay, txv, sop, eop, sof, trdy, stall;
  logic [15:0] addr, len, pkts, sofs, errs;
  logic [31:0] wdata, rdata;
  logic [7:0] sdata, tdata;
  logic [2:0] ssen;
  logic [1:0] spl;
  int n_errors, check_count;
  msip_packetizer #(.CYCLE_CLKS(13'h0028)) dut (.SYS_CLK_I(clk), .RESETN_I(rstn),
    .REG_WR_I(wr), .REG_RD_I(rd), .REG_ADDR_I(addr), .REG_WDATA_I(wdata),
    .REG_RDATA_O(rdata), .REG_RACK_O(rack), .SRC_VALID_I(sval), .SRC_DATA_I(sdata),
    .SRC_READY_O(srdy), .SRC_SENSOR_O(ssen), .SRC_PLANE_O(spl), .SRC_BIN_O(sbin),
    .SRC_BAYER_O(sbay), .TX_VALID_O(txv), .TX_DATA_O(tdata), .TX_SOP_O(sop),
    .TX_EOP_O(eop), .TX_SOF_O(sof), .TX_READY_I(trdy));
  msip_host_sink u_sink (.clk_i(clk), .rst_n_i(rstn), .stall_i(stall), .valid_i(txv),
    .data_i(tdata), .sop_i(sop), .eop_i(eop), .sof_i(sof), .ready_o(trdy),
    .len_o(len), .pkts_o(pkts), .sofs_o(sofs), .errs_o(errs));
  initial begin
    clk = 0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
    if (sval && srdy) sdata <= sdata + 8'h01;
  task end_sim;
    $display("checks %0d errors %0d", check_count, n_errors);
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  task chk(input [31:0] got, input [31:0] exp);
    check_count++;
    if (got !== exp) begin
      n_errors++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task wr_reg(input [15:0] a, input [31:0] d);
    @(posedge clk) #1;
    {wr, addr, wdata} = {1'b1, a, d};
    @(posedge clk) #1;
    wr = 0;
  endtask
  task rd_reg(input [15:0] a, output [31:0] d);
    @(posedge clk) #1;
    {rd, addr} = {1'b1, a};
    @(posedge clk) #1;
    rd = 0;
    d = rdata;
  endtask
  task rd_chk(input [15:0] a, input [31:0] e);
    logic [31:0] v;
    rd_reg(a, v);
    chk(v, e);
  endtask
  // Polls the packet count until the recount finishes.
  task ppf_wait(input [31:0] e);
    logic [31:0] v;
    int i;
    for (i = 0; i < 10000; i++) begin
      rd_reg(`MSIP_OFS_PPF, v);
      if (v[31] === 1'b0) break;
    end
    if (i == 10000) begin
      n_errors++;
      end_sim();
    end else begin
      chk(v, e);
    end
  endtask
  task t_reset;
    rd_chk(`MSIP_OFS_MODE, 0);
    rd_chk(`MSIP_OFS_START, 32'h82000000);
    rd_chk(`MSIP_OFS_BPP, 32'h00002000);
    rd_chk(`MSIP_OFS_BINFO, 0);
    wr_reg(16'h0100, 32'hFFFFFFFF);
    rd_chk(16'h0100, 0);
    ppf_wait((`MSIP_FRAME_FULL + 8191) / 8192);
  endtask
  task t_modes;
    logic [2:0] m[6];
    logic [1:0] b[6];
    m = '{0, 1, 2, 3, 6, 7};
    b = '{0, 0, 1, 3, 0, 0};
    for (int i = 0; i < 6; i++) begin
      wr_reg(`MSIP_OFS_MODE, m[i]);
      rd_chk(`MSIP_OFS_MODE, m[i]);
      rd_chk(`MSIP_OFS_BINFO, b[i]);
    end
    wr_reg(`MSIP_OFS_MODE, 4);
    wr_reg(`MSIP_OFS_MODE, 5);
    rd_chk(`MSIP_OFS_MODE, 7);
    wr_reg(`MSIP_OFS_BINFO, 3);
    rd_chk(`MSIP_OFS_BINFO, 0);
  endtask
  task t_bpp;
    wr_reg(`MSIP_OFS_BPP, 32'h00000010);
    rd_chk(`MSIP_OFS_BPP, 32'h00000198);
    wr_reg(`MSIP_OFS_BPP, 32'h00003000);
    rd_chk(`MSIP_OFS_BPP, 32'h00002000);
    wr_reg(`MSIP_OFS_MODE, 2);
    ppf_wait((`MSIP_FRAME_HALF + 8191) / 8192);
  endtask
  // Start sensor 2 is only used in mode 3, where stitching is unaffected.
  task t_stream;
    wr_reg(`MSIP_OFS_MODE, 3);
    wr_reg(`MSIP_OFS_START, 32'h82000002);
    wr_reg(`MSIP_OFS_START, 32'h82000007);
    rd_chk(`MSIP_OFS_START, 32'h82000002);
    wr_reg(`MSIP_OFS_BPP, 408);
    ppf_wait((`MSIP_FRAME_HALF + 407) / 408);
    stall = 1;
    wr_reg(`MSIP_OFS_ISOEN, 1);
    repeat (4) @(posedge clk);
    #1;
    chk(ssen, 2);
    chk({sbin, sbay}, 2'h3);
    chk(spl, 0);
    chk(srdy, 1);
    rd_chk(`MSIP_OFS_ISOEN, 3);
    for (int i = 0; i < 20000 && pkts < 3; i++) @(posedge clk);
    #1;
    chk(pkts >= 3, 1);
    chk(len, 408);
    chk(sofs, 1);
    chk(errs, 0);
  endtask
  initial begin
    {rstn, wr, rd, sval, stall, sdata, addr, wdata} = '0;
    {n_errors, check_count} = '0;
    repeat (2) @(posedge clk);
    #1;
    {rstn, sval} = 2'b11;
    t_reset();
    t_modes();
    t_bpp();
    t_stream();
    end_sim();
  end
endmodule
`default_nettype wire
